// *** rtl/audio_rx_defs.vh ***
`ifndef AUDIO_RX_DEFS_VH
`define AUDIO_RX_DEFS_VH

// register offsets
`define ADDR_FORMAT_LIMITER      8'h35
`define ADDR_FRAMING_CONTROL     8'h36

// reset values
`define RST_FORMAT_LIMITER       8'h01
`define RST_FRAMING_CONTROL      8'h01

// field positions in the format register
`define FMT_WORD_FORMAT_LSB      0
`define FMT_WORD_FORMAT_MSB      2

// field positions in the framing register
`define FRM_CLOCK_EDGE_BIT       0
`define FRM_WS_POLARITY_BIT      1
`define FRM_BIT_ORDER_BIT        2
`define FRM_FRAME_SIZE_LSB       3
`define FRM_FRAME_SIZE_MSB       4
`define FRM_RIGHT_FIRST_BIT      5

// word format codes
`define WFMT_I2S                 3'h0
`define WFMT_LEFT_JUST           3'h1
`define WFMT_RJ16                3'h4
`define WFMT_RJ18                3'h5
`define WFMT_RJ20                3'h6
`define WFMT_RJ24                3'h7

// frame size codes
`define FSIZE_64                 2'h0
`define FSIZE_48                 2'h1
`define FSIZE_32                 2'h2

// bit-clock cycles per half frame
`define HALF_BITS_64             7'h20
`define HALF_BITS_48             7'h18
`define HALF_BITS_32             7'h10

// right-justified sample widths
`define RJ_WIDTH_16              7'h10
`define RJ_WIDTH_18              7'h12
`define RJ_WIDTH_20              7'h14
`define RJ_WIDTH_24              7'h18

// sample width presented downstream
`define SAMPLE_BITS              7'h18

`endif

// *** rtl/audio_pin_sync.v ***
`timescale 1ns/1ps

module audio_pin_sync #(
  parameter WIDTH = 4
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             rst,
  // asynchronous pins in, synchronised levels out
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta;

  always @(posedge clk_sys) begin
    if (rst) begin
      meta <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// *** rtl/serial_audio_input_receiver.v ***
// Function
// - four channels: line 0 pair 0, line 1 pair 1
// - clock, select, data are slave inputs only
// - format 000 i2s, 001 left justified default
// - codes 100..111 right justified 16/18/20/24
// - edge field 0 samples on falling edge
// - edge field 1, default, samples rising edge
// - frame size 64/48/32 cycles, default 64
// - polarity picks select level of first word
// - bit order: msb first or lsb first
// - channel order: first word left or right
`timescale 1ns/1ps
`include "audio_rx_defs.vh"

module serial_audio_input_receiver (
  // core clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // control register port
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // serial audio pins, all driven by the source
  input  wire        bit_clock,
  input  wire        word_select,
  input  wire        data_line_pair0,
  input  wire        data_line_pair1,
  // assembled samples, left aligned
  output reg  [23:0] left0,
  output reg  [23:0] right0,
  output reg  [23:0] left1,
  output reg  [23:0] right1,
  output reg         sample_valid
);

  // control registers
  reg  [7:0]  format_limiter;
  reg  [7:0]  framing_control;

  wire [2:0]  word_format;
  wire        clock_edge;
  wire        ws_polarity;
  wire        lsb_first;
  wire [1:0]  frame_size;
  wire        right_first;

  assign word_format = format_limiter[`FMT_WORD_FORMAT_MSB:
                                      `FMT_WORD_FORMAT_LSB];
  assign clock_edge  = framing_control[`FRM_CLOCK_EDGE_BIT];
  assign ws_polarity = framing_control[`FRM_WS_POLARITY_BIT];
  assign lsb_first   = framing_control[`FRM_BIT_ORDER_BIT];
  assign frame_size  = framing_control[`FRM_FRAME_SIZE_MSB:
                                       `FRM_FRAME_SIZE_LSB];
  assign right_first = framing_control[`FRM_RIGHT_FIRST_BIT];

  always @(posedge clk_sys) begin
    if (rst) begin
      format_limiter  <= `RST_FORMAT_LIMITER;
      framing_control <= `RST_FRAMING_CONTROL;
    end else if (reg_wr) begin
      if (reg_addr == `ADDR_FORMAT_LIMITER)
        format_limiter <= reg_wdata;
      if (reg_addr == `ADDR_FRAMING_CONTROL)
        framing_control <= reg_wdata;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `ADDR_FORMAT_LIMITER:  reg_rdata <= format_limiter;
        `ADDR_FRAMING_CONTROL: reg_rdata <= framing_control;
        default:               reg_rdata <= 8'h00;
      endcase
    end
  end

  // pin synchronisers
  wire [3:0]  pins_sync;
  wire        sck_s;
  wire        ws_s;
  wire        sd0_s;
  wire        sd1_s;

  audio_pin_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     ({data_line_pair1, data_line_pair0,
               word_select, bit_clock}),
    .dout    (pins_sync)
  );

  assign sck_s = pins_sync[0];
  assign ws_s  = pins_sync[1];
  assign sd0_s = pins_sync[2];
  assign sd1_s = pins_sync[3];

  // bit clock edge detection
  reg         sck_d;
  reg  [1:0]  settle;
  wire        settled;
  wire        sck_rise;
  wire        sck_fall;
  wire        capture;

  always @(posedge clk_sys) begin
    if (rst)
      sck_d <= 1'b0;
    else
      sck_d <= sck_s;
  end

  // synchroniser leaves reset at 0 whatever the pin level, so edges
  // are ignored until live levels have reached sck_d
  always @(posedge clk_sys) begin
    if (rst)
      settle <= 2'h0;
    else if (settle != 2'h3)
      settle <= settle + 2'h1;
  end

  assign settled  = (settle == 2'h3);
  assign sck_rise = settled & sck_s & ~sck_d;
  assign sck_fall = settled & ~sck_s & sck_d;
  // capture on the edge opposite to where the source changes
  assign capture  = clock_edge ? sck_rise
                               : sck_fall;

  // slot geometry from format and frame size
  reg  [6:0]  half_bits;
  reg  [6:0]  rj_width;
  reg  [6:0]  word_len;
  reg  [6:0]  word_start;
  wire        is_rj;
  wire        is_i2s;

  assign is_rj  = word_format[2];
  assign is_i2s = (word_format == `WFMT_I2S);

  always @* begin
    case (frame_size)
      `FSIZE_48: half_bits = `HALF_BITS_48;
      `FSIZE_32: half_bits = `HALF_BITS_32;
      default:   half_bits = `HALF_BITS_64;
    endcase
  end

  always @* begin
    case (word_format)
      `WFMT_RJ16: rj_width = `RJ_WIDTH_16;
      `WFMT_RJ18: rj_width = `RJ_WIDTH_18;
      `WFMT_RJ20: rj_width = `RJ_WIDTH_20;
      `WFMT_RJ24: rj_width = `RJ_WIDTH_24;
      default:    rj_width = `RJ_WIDTH_24;
    endcase
  end

  always @* begin
    word_len   = `SAMPLE_BITS;
    word_start = 7'h00;
    if (is_rj) begin
      // word ends on the last cycle of the half frame
      word_len   = (rj_width > half_bits) ? half_bits : rj_width;
      word_start = half_bits - word_len;
    end else if (is_i2s) begin
      word_start = 7'h01;
      word_len   = (half_bits - 7'h01 < `SAMPLE_BITS) ?
                   half_bits - 7'h01 : `SAMPLE_BITS;
    end else begin
      word_start = 7'h00;
      word_len   = (half_bits < `SAMPLE_BITS) ?
                   half_bits : `SAMPLE_BITS;
    end
  end

  // bit position within the current half frame
  reg         ws_prev;
  reg         ws_primed;
  reg  [6:0]  bit_pos;
  wire        new_half;
  wire [6:0]  next_pos;
  wire [6:0]  k;
  wire        in_word;
  reg  [4:0]  place;

  // first capture after reset only learns the select level, so a
  // reset value unlike the pin cannot fake a half-frame boundary
  assign new_half = ws_primed & (ws_s != ws_prev);
  assign next_pos = new_half ? 7'h00 :
                    (bit_pos == 7'h7f) ? bit_pos : bit_pos + 7'h01;
  assign k        = next_pos - word_start;
  assign in_word  = (next_pos >= word_start) &&
                    (next_pos < word_start + word_len);

  always @* begin
    if (lsb_first)
      place = k[4:0] + 5'h18 - word_len[4:0];
    else
      place = 5'h17 - k[4:0];
  end

  // shift assembly, both lines in parallel
  reg  [23:0] acc0;
  reg  [23:0] acc1;
  wire [23:0] base0;
  wire [23:0] base1;
  wire [23:0] bit0;
  wire [23:0] bit1;
  wire [23:0] next_acc0;
  wire [23:0] next_acc1;

  assign base0     = new_half ? 24'h00_0000 : acc0;
  assign base1     = new_half ? 24'h00_0000 : acc1;
  assign bit0      = {23'h00_0000, sd0_s} << place;
  assign bit1      = {23'h00_0000, sd1_s} << place;
  assign next_acc0 = in_word ? (base0 | bit0) : base0;
  assign next_acc1 = in_word ? (base1 | bit1) : base1;

  // first word of each pair is held until the second completes
  reg  [23:0] first0;
  reg  [23:0] first1;
  reg         have_first;

  always @(posedge clk_sys) begin
    if (rst) begin
      ws_prev      <= 1'b0;
      ws_primed    <= 1'b0;
      bit_pos      <= 7'h7f;
      acc0         <= 24'h00_0000;
      acc1         <= 24'h00_0000;
      first0       <= 24'h00_0000;
      first1       <= 24'h00_0000;
      have_first   <= 1'b0;
      left0        <= 24'h00_0000;
      right0       <= 24'h00_0000;
      left1        <= 24'h00_0000;
      right1       <= 24'h00_0000;
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= 1'b0;
      if (capture) begin
        ws_prev <= ws_s;
        ws_primed <= 1'b1;
        bit_pos <= next_pos;
        acc0    <= next_acc0;
        acc1    <= next_acc1;
        if (new_half) begin
          if (ws_prev == ws_polarity) begin
            // first word just ended
            first0     <= acc0;
            first1     <= acc1;
            have_first <= 1'b1;
          end else if (have_first) begin
            // second word ended: present the pair
            have_first   <= 1'b0;
            sample_valid <= 1'b1;
            if (right_first) begin
              left0  <= acc0;
              right0 <= first0;
              left1  <= acc1;
              right1 <= first1;
            end else begin
              left0  <= first0;
              right0 <= acc0;
              left1  <= first1;
              right1 <= acc1;
            end
          end
        end
      end
    end
  end

endmodule

// *** dv/audio_rx_chk.sv ***
`timescale 1ns/1ps
module audio_rx_chk (
  // core side
  input logic        clk_sys,
  input logic        rst,
  input logic [7:0]  reg_addr,
  input logic        reg_wr,
  input logic [7:0]  reg_wdata,
  input logic [7:0]  reg_rdata,
  // link and samples
  input logic        bit_clock,
  input logic [23:0] left0,
  input logic [23:0] right0,
  input logic [23:0] left1,
  input logic [23:0] right1,
  input logic        sample_valid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic       bck_q;
  logic [5:0] quiet;
  // cycles since the bit clock pin last moved
  always @(posedge clk_sys) begin
    bck_q <= bit_clock;
    if (rst || bit_clock != bck_q)
      quiet <= 6'h00;
    else if (quiet != 6'h3f)
      quiet <= quiet + 6'h01;
  end
  property p_gap; sample_valid |=> !sample_valid [*8]; endproperty
  a_gap: assert property (p_gap) else $error("valid held");
  property p_hold; !sample_valid |-> $stable({left0, right0, left1, right1});
  endproperty
  a_hold: assert property (p_hold) else $error("samples moved");
  property p_near; sample_valid |-> quiet < 6'h09; endproperty
  a_near: assert property (p_near) else $error("valid late");
  property p_zero;
    $fell(rst) |-> !sample_valid && left0 == 24'h00_0000 &&
      right0 == 24'h00_0000 && left1 == 24'h00_0000 &&
      right1 == 24'h00_0000;
  endproperty
  a_zero: assert property (p_zero) else $error("not cleared");
  property p_def; $fell(rst) && reg_addr == 8'h36 && !reg_wr
    |=> reg_rdata == 8'h01; endproperty
  a_def: assert property (p_def) else $error("framing default");
  property p_unmap; !(reg_addr inside {8'h35, 8'h36}) |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_wr36; reg_wr && reg_addr == 8'h36 ##1 reg_addr == 8'h36
    |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_wr36: assert property (p_wr36) else $error("framing write");
  property p_wr35; reg_wr && reg_addr == 8'h35 ##1 reg_addr == 8'h35
    |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_wr35: assert property (p_wr35) else $error("format write");
endmodule

// *** dv/audio_source.sv ***
`timescale 1ns/1ps
module audio_source (
  // all pins driven here, receiver is slave
  output logic bit_clock,
  output logic word_select,
  output logic data_line_pair0,
  output logic data_line_pair1
);
  int len;
  initial
    {bit_clock, word_select, data_line_pair0, data_line_pair1} = 4'h8;
  function automatic logic pick(logic [23:0] v, logic lsb, int k);
    return lsb ? v[24 - len + k] : v[23 - k];
  endfunction
  // change on the idle edge, hold across the capture edge
  task automatic put(logic e, logic w, logic b0, logic b1);
    bit_clock = !e;
    {word_select, data_line_pair0, data_line_pair1} = {w, b0, b1};
    #80 bit_clock = e;
    #80;
  endtask
  // two frames, then one bit back at the first level
  task automatic send(logic [2:0] f, logic [7:0] c, logic [23:0] w [4]);
    int h;
    int s;
    h = c[4:3] == 2'h1 ? 24 : c[4:3] == 2'h2 ? 16 : 32;
    s = f == 3'h0;
    len = f[2] ? (f == 3'h7 ? 24 : 16 + 2 * f[1:0]) : 24;
    if (len > h - s)
      len = h - s;
    if (f[2])
      s = h - len;
    #3;
    for (int q = 0; q < 4; q++)
      for (int p = 0; p < h; p++)
        if (p >= s && p < s + len)
          put(c[0], c[1] ^ q[0], pick(w[q[0]], c[2], p - s),
            pick(w[2 + q[0]], c[2], p - s));
        else
          put(c[0], c[1] ^ q[0], p[0], !p[0]);
    put(c[0], c[1], 1'b0, 1'b1);
    {data_line_pair0, data_line_pair1} = 2'h2;
  endtask
endmodule

// *** dv/serial_audio_input_receiver_test.sv ***
`timescale 1ns/1ps
module serial_audio_input_receiver_test;
  logic        clk_sys, rst, reg_wr, sample_valid;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        bit_clock, word_select, data_line_pair0, data_line_pair1;
  logic [23:0] left0, right0, left1, right1, m;
  logic [23:0] got [4];
  logic [23:0] w [4] = '{24'hc3_a596, 24'h5a_0f3c, 24'h96_e1d2, 24'h2d_7b48};
  // format code above framing byte
  logic [10:0] rows [7] = '{11'h001, 11'h108, 11'h411, 11'h505, 11'h60b,
                            11'h721, 11'h036};
  int          err_total, comparisons, cycles;
  serial_audio_input_receiver i_serial_audio_input_receiver (.*);
  audio_source i_audio_source (.*);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = !clk_sys;
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (sample_valid === 1'b1)
      got <= '{left0, right0, left1, right1};
    if (cycles == 30000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(string n, logic [23:0] e, logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1 chk("reg_rdata", {16'h0000, e}, {16'h0000, reg_rdata});
  endtask
  initial begin
    {rst, reg_wr, reg_addr, reg_wdata} = 18'h2_3600;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h35, 8'h01);
    rd(8'h36, 8'h01);
    $display("reset defaults done");
    foreach (rows[i]) begin
      wr(8'h35, {5'h00, rows[i][10:8]});
      wr(8'h36, rows[i][7:0]);
      i_audio_source.send(rows[i][10:8], rows[i][7:0], w);
      repeat (2) @(posedge clk_sys);
      m = 24'hff_ffff << (24 - i_audio_source.len);
      chk("left0", w[rows[i][5]] & m, got[0]);
      chk("right0", w[!rows[i][5]] & m, got[1]);
      chk("left1", w[2 + rows[i][5]] & m, got[2]);
      chk("right1", w[3 - rows[i][5]] & m, got[3]);
      $display("row %0d done", i);
    end
    wr(8'h35, 8'he7);
    rd(8'h35, 8'he7);
    wr(8'h37, 8'hff);
    rd(8'h37, 8'h00);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h35, 8'h01);
    rd(8'h36, 8'h01);
    chk("left0", 24'h00_0000, left0);
    chk("right0", 24'h00_0000, right0);
    chk("left1", 24'h00_0000, left1);
    chk("right1", 24'h00_0000, right1);
    chk("sample_valid", 24'h00_0000, {23'h00_0000, sample_valid});
    $display("register and reset test done");
    end_of_test();
  end
endmodule
bind serial_audio_input_receiver audio_rx_chk i_audio_rx_chk (.*);
